// ---- hdl/dap_pkg.sv ----
package dap_pkg;
  // frame and word layout
  localparam int          FRAME_BITS     = 16;
  localparam int          ACQ_EDGE       = 2;        // sample on 2nd rising edge
  localparam int          CTRL_BITS      = 8;
  localparam int          AXIS_POS       = 3;
  localparam int          PMODE_POS      = 0;
  localparam int          RESULT_BITS    = 12;
  localparam int          TEMP_BITS      = 10;
  localparam logic [11:0] ST_OFFSET      = 12'h0CD;  // 0.75 g shift, 205 counts
  localparam logic [7:0]  CTRL_RESET     = 8'h04;
  localparam logic [7:0]  CTRL_DEFAULT   = 8'h04;    // x axis, normal power
  // link clock made by host divider from 50 MHz
  localparam int          MCLK_HZ        = 50000000;
  localparam int          SCLK_MAX_HZ    = 2000000;
  localparam int          SCLK_HALF      = (MCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int          HALF_W         = 5;
  // power-up delay in link clocks at 2 MHz
  localparam int          WAKE_NS        = 5000;
  localparam int          SCLK_NS        = 500;
  localparam int          WAKE_SCLKS     = (WAKE_NS + SCLK_NS - 1) / SCLK_NS;
  localparam int          FIFO_DEPTH     = 4;
  localparam int          FIFO_WIDTH     = 16;
endpackage

// ---- hdl/dap_link_if.sv ----
`timescale 1ns/1ns
interface dap_link_if;
  logic sclk;
  logic accel_select_n;
  logic temp_select_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // released line reads low, as if pulled down
  assign dout = dout_oe & dout_o;
  modport dev  (input sclk, accel_select_n, temp_select_n, din,
                output dout_o, dout_oe);
  modport host (output sclk, accel_select_n, temp_select_n, din,
                input dout);
endinterface

// ---- hdl/dap_fifo.sv ----
`timescale 1ns/1ns
module dap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  // storage written only on accepted word
  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  // pointers, extra bit tells full from empty
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // dap_fifo

// ---- hdl/dap_dev.sv ----
`timescale 1ns/1ns
// Function
// - conversion spans sixteen link clock periods
// - samples resume about 5 us after wake
// - host allows extra sensor settling after wake
// - result bits change on falling link edge
// - control bits captured on rising link edge
// - active-low temperature select frames temperature read
// - accel select low starts conversion, frames result
// - conversion advances only on host link clock
// - self-check input shifts both axes 0.75 g
// - host link clock duty 40/60 to 60/40
// - select high releases data output
// - select low starts driving data output
// - host never asserts both selects together
// - sample on second rising edge after select
// - axis bit 0 x, 1 y
// - wake on sixteenth rising edge after clearing
module dap_dev
  import dap_pkg::*;
(
  dap_link_if.dev          link,
  input  wire logic [11:0] x_sample_i,
  input  wire logic [11:0] y_sample_i,
  input  wire logic [9:0]  temp_sample_i,
  input  wire logic        self_check_in,
  output logic             powered_down_o,
  output logic [7:0]       ctrl_o
);
  // the device has no clock but the link clock; selects act as async reset
  logic        frame_n;
  logic [4:0]  rise_cnt;
  logic [7:0]  ctrl;
  logic [7:0]  ctrl_shift;
  logic [15:0] out_shift;
  logic        shutdown;
  logic        wake_pend;
  logic [3:0]  wake_cnt;
  logic        dout_bit;
  logic [11:0] accel_pick;
  assign frame_n = link.accel_select_n & link.temp_select_n;

  // pick axis and add self-check stimulus
  always_comb
  begin
    accel_pick = ctrl[AXIS_POS] ? y_sample_i : x_sample_i;
    if (self_check_in)
    begin
      accel_pick = accel_pick + ST_OFFSET;
    end
  end

  // rising-edge counter within a frame; resets when frame closes
  always_ff @(posedge link.sclk or posedge frame_n)
  begin
    if (frame_n)
    begin
      rise_cnt <= '0;
    end
    else if (rise_cnt == 5'(FRAME_BITS - 1))
    begin
      rise_cnt <= '0; // select held low: next conversion
    end
    else
    begin
      rise_cnt <= rise_cnt + 5'd1;
    end
  end

  // control bits shifted in on rising edges, first 8 of each accel-select frame
  always_ff @(posedge link.sclk or posedge link.accel_select_n)
  begin
    if (link.accel_select_n)
    begin
      ctrl_shift <= '0;
    end
    else if (rise_cnt < 5'(CTRL_BITS))
    begin
      ctrl_shift <= {ctrl_shift[6:0], link.din};
    end
  end

  // control register updated at 8th rising edge; kept in shutdown
  always_ff @(posedge link.sclk)
  begin
    if (!link.accel_select_n && rise_cnt == 5'(CTRL_BITS - 1))
    begin
      ctrl <= {ctrl_shift[6:0], link.din};
    end
  end

  // power mode: shutdown at once, wake at 16th edge then 5 us delay
  always_ff @(posedge link.sclk)
  begin
    if (!link.accel_select_n && rise_cnt == 5'(CTRL_BITS - 1))
    begin
      if (link.din == 1'b1)
      begin
        shutdown  <= 1'b1;
        wake_pend <= 1'b0;
      end
      else if (shutdown)
      begin
        wake_pend <= 1'b1;
      end
    end
    else if (wake_pend && rise_cnt == 5'(FRAME_BITS - 1))
    begin
      shutdown  <= 1'b0;
      wake_pend <= 1'b0;
      wake_cnt  <= 4'(WAKE_SCLKS);
    end
    else if (wake_cnt != 4'd0)
    begin
      wake_cnt <= wake_cnt - 4'd1;
    end
  end

  // load result at sample edge, shift on falling edges
  always_ff @(negedge link.sclk or posedge frame_n)
  begin
    if (frame_n)
    begin
      out_shift <= '0;
      dout_bit  <= 1'b0;
    end
    else if (rise_cnt == 5'(ACQ_EDGE))
    begin
      // one spare lead bit so the last result bit leaves on the 15th fall
      if (!link.temp_select_n)
      begin
        out_shift <= {2'b00, temp_sample_i, 4'h0};
      end
      else if (shutdown || wake_cnt != 4'd0)
      begin
        out_shift <= '0;
      end
      else
      begin
        out_shift <= {1'b0, accel_pick, 3'b000};
      end
      dout_bit <= 1'b0;
    end
    else
    begin
      dout_bit  <= out_shift[15];
      out_shift <= {out_shift[14:0], 1'b0};
    end
  end

  assign link.dout_o  = dout_bit;
  assign link.dout_oe = !frame_n;
  assign powered_down_o = shutdown;
  assign ctrl_o = ctrl;
endmodule // dap_dev

// ---- hdl/dap_host.sv ----
`timescale 1ns/1ns
module dap_host
  import dap_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  dap_link_if.host         link,
  input  wire logic        req_valid_i,
  input  wire logic        req_temp_i,
  input  wire logic [7:0]  req_ctrl_i,
  output logic             req_ready_o,
  output logic [15:0]      rsp_data_o,
  output logic             rsp_valid_o,
  input  wire logic        rsp_ready_i
);
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SETUP = 2'b01,
    HS_SHIFT = 2'b10,
    HS_PUSH  = 2'b11
  } dap_hstate_e;
  dap_hstate_e  state;
  logic [HALF_W-1:0] div;
  logic        sclk;
  logic [4:0]  edges;
  logic [7:0]  tx;
  logic [15:0] rx;
  logic        is_temp;
  logic        dout_s1;
  logic        dout_s2;
  logic        f_in_ready;
  logic        tick;
  assign tick = div == HALF_W'(SCLK_HALF - 1);

  // data line crosses from link into mclk domain
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dout_s1 <= 1'b0;
      dout_s2 <= 1'b0;
    end
    else
    begin
      dout_s1 <= link.dout;
      dout_s2 <= dout_s1;
    end
  end

  // divider makes link clock of about 1.92 MHz (26 mclk period), 50/50 duty
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div <= '0;
    end
    else
    begin
      div <= (tick || state != HS_SHIFT) ? '0 : div + 1'b1;
    end
  end

  // frame sequencer
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state   <= HS_IDLE;
      sclk    <= 1'b0;
      edges   <= '0;
      tx      <= '0;
      rx      <= '0;
      is_temp <= 1'b0;
    end
    else
    begin
      unique case (state)
        HS_IDLE:
        begin
          if (req_valid_i)
          begin
            tx      <= req_ctrl_i;
            is_temp <= req_temp_i; // one select only
            edges   <= '0;
            state   <= HS_SETUP;
          end
        end
        HS_SETUP:
        begin
          state <= HS_SHIFT;
        end
        HS_SHIFT:
        begin
          if (tick)
          begin
            sclk <= !sclk;
            if (!sclk)
            begin
              // rising edge: sample dout, stable since falling edge
              rx    <= {rx[14:0], dout_s2};
              edges <= edges + 5'd1;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0}; // next bit after falling edge
              if (edges == 5'(FRAME_BITS))
              begin
                state <= HS_PUSH; // all 16 periods given
              end
            end
          end
        end
        HS_PUSH:
        begin
          if (f_in_ready)
          begin
            state <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk           = sclk;
  assign link.accel_select_n = !(state != HS_IDLE && !is_temp);
  assign link.temp_select_n  = !(state != HS_IDLE && is_temp);
  assign link.din            = tx[7];
  assign req_ready_o         = state == HS_IDLE;

  // results buffered; a stalled reader holds the sequencer
  dap_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (rx),
    .in_valid_i  (state == HS_PUSH),
    .in_ready_o  (f_in_ready),
    .out_data_o  (rsp_data_o),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i)
  );
endmodule // dap_host

// ---- tb/dap_link_monitor.sv ----
`timescale 1ns/1ns
module dap_link_monitor
  import dap_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic sclk,
  input wire logic accel_select_n,
  input wire logic temp_select_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe
);
  logic       sclk_q;
  logic [7:0] hi_cnt;
  logic [7:0] edges;
  wire        idle = accel_select_n && temp_select_n;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // link clock seen from mclk: high-phase length, rising edges per frame
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      sclk_q <= 1'b0;
      hi_cnt <= 8'h00;
      edges  <= 8'h00;
    end
    else
    begin
      sclk_q <= sclk;
      hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
      edges  <= idle ? 8'h00 : edges + 8'(sclk && !sclk_q);
    end
  chk_sel_exclusive: assert property (accel_select_n || temp_select_n)
    else $error("both selects low");
  chk_out_release: assert property ($past(idle) && idle |-> !dout_oe)
    else $error("dout driven while idle");
  chk_out_drive: assert property ($fell(idle) |-> ##1 dout_oe)
    else $error("dout not driven in frame");
  chk_out_edge: assert property ($changed(dout_o) && dout_oe && $past(dout_oe) |-> !sclk)
    else $error("dout moved off falling edge");
  chk_in_hold: assert property ($rose(sclk) |-> $stable(din))
    else $error("din moved at rising edge");
  chk_frame_len: assert property ($rose(idle) |-> edges == 8'(FRAME_BITS))
    else $error("frame edge count wrong");
  chk_frame_setup: assert property ($fell(accel_select_n) |-> !sclk [*2])
    else $error("clock before select setup");
  chk_clock_duty: assert property ($fell(sclk) |-> hi_cnt * 10 >= 8 * SCLK_HALF
    && hi_cnt * 10 <= 12 * SCLK_HALF)
    else $error("link clock duty out of range");
  cov_accel_frame: cover property ($rose(accel_select_n));
  cov_temp_frame: cover property ($rose(temp_select_n));
  cov_out_drive: cover property ($rose(dout_oe));
endmodule // dap_link_monitor

// ---- tb/test_dual_axis_accel_serial_port.sv ----
`timescale 1ns/1ns
module test_dual_axis_accel_serial_port
  import dap_pkg::*;
  ();
  logic        mclk_i, rst_b_i, req_valid_i, req_temp_i, req_ready_o;
  logic        rsp_valid_o, rsp_ready_i, self_check_in, powered_down_o;
  logic [7:0]  req_ctrl_i, ctrl_o, c;
  logic [15:0] rsp_data_o, r;
  logic [11:0] x_sample_i, y_sample_i, e;
  logic [9:0]  temp_sample_i;
  logic [31:0] seed;
  int          n_mismatch, compares, stuck;
  dap_link_if link ();
  dap_host dap_host_inst (.mclk_i, .rst_b_i, .link, .req_valid_i, .req_temp_i, .req_ctrl_i,
    .req_ready_o, .rsp_data_o, .rsp_valid_o, .rsp_ready_i);
  dap_dev dap_dev_inst (.link, .x_sample_i, .y_sample_i, .temp_sample_i, .self_check_in,
    .powered_down_o, .ctrl_o);
  dap_link_monitor dap_link_monitor_inst (.mclk_i, .rst_b_i, .sclk(link.sclk),
    .accel_select_n(link.accel_select_n), .temp_select_n(link.temp_select_n),
    .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe));
  // 50 MHz system clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // fixed-level bits kept as the device wants, top bit left random
  function automatic logic [7:0] mk(input logic ax, input logic pm);
    return {seed[0], 3'h0, ax, 1'h1, 1'h0, pm};
  endfunction
  // accel: four lead zeros, 12 bits; temp: zeros, 10 bits, one trailing zero
  function automatic bit has(input logic [15:0] v, input logic [11:0] x, input int w);
    return v === {4'h0, (w == 12) ? x : 12'(x << 1)};
  endfunction
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // request held from a falling edge up to the rising edge that takes it
  task automatic send(input logic [7:0] ctl, input logic tmp);
    int n = 0;
    @(negedge mclk_i);
    req_valid_i = 1'b1;
    req_ctrl_i = ctl;
    req_temp_i = tmp;
    do @(posedge mclk_i) n++; while (req_ready_o !== 1'b1 && n < 3000);
    chk(n < 3000, "request not taken");
    @(negedge mclk_i);
    req_valid_i = 1'b0;
  endtask
  task automatic recv();
    int n = 0;
    @(negedge mclk_i);
    rsp_ready_i = 1'b1;
    do @(posedge mclk_i) n++; while (rsp_valid_o !== 1'b1 && n < 3000);
    r = rsp_data_o;
    chk(n < 3000, "no response");
    @(negedge mclk_i);
    rsp_ready_i = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] ctl, input logic tmp);
    send(ctl, tmp);
    recv();
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // some twenty frames of about 420 cycles, with wide margin
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    n_mismatch++;
    conclude();
  end
  // main sequence
  initial
  begin
    seed = 32'h00013A99;
    n_mismatch = 0;
    compares = 0;
    {rst_b_i, req_valid_i, req_temp_i, rsp_ready_i, self_check_in} = 5'h00;
    {req_ctrl_i, x_sample_i, y_sample_i, temp_sample_i} = 42'h0;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    // a control word acts from the next frame on, so each is sent twice
    for (int i = 0; i < 4; i++)
    begin
      x_sample_i = 12'(rnd() & 32'h7FF);
      y_sample_i = i == 3 ? 12'hF32 : 12'(rnd() & 32'h7FF);
      self_check_in = i[1];
      c = mk(i[0], 1'h0);
      xfer(c, 1'h0);
      chk(ctrl_o === c, "control word");
      xfer(c, 1'h0);
      e = (i[0] ? y_sample_i : x_sample_i) + (i[1] ? ST_OFFSET : 12'h000);
      chk(has(r, e, 12), "axis result");
      $display("axis test %0d done", i);
    end
    temp_sample_i = 10'(rnd());
    xfer(c, 1'h1);
    chk(has(r, {2'h0, temp_sample_i}, 10), "temperature");
    $display("temperature test done");
    // shutdown, a frame inside it, wake, then wait out the restart
    self_check_in = 1'b0;
    xfer(mk(1'h0, 1'h1), 1'h0);
    chk(powered_down_o === 1'b1, "no shutdown");
    xfer(mk(1'h0, 1'h1), 1'h0);
    chk(r === 16'h0000, "shutdown data");
    xfer(mk(1'h0, 1'h0), 1'h0);
    chk(powered_down_o === 1'b0, "no wake");
    xfer(mk(1'h0, 1'h0), 1'h0); // restart frame, extra settling
    xfer(mk(1'h0, 1'h0), 1'h0);
    chk(has(r, x_sample_i, 12), "no samples after wake");
    $display("power test done");
    // far side stalls: four words fill the buffer, a fifth frame stalls
    // in push, so a sixth request must wait
    c = mk(1'h0, 1'h0);
    stuck = 0;
    repeat (5) send(c, 1'h0);
    @(negedge mclk_i);
    req_valid_i = 1'b1;
    repeat (1000) @(negedge mclk_i) stuck += int'(req_ready_o !== 1'b0);
    req_valid_i = 1'b0;
    chk(stuck == 0, "full buffer took a request");
    repeat (5)
    begin
      recv();
      chk(has(r, x_sample_i, 12), "drained word");
    end
    chk(rsp_valid_o === 1'b0, "buffer not empty");
    $display("buffer test done");
    conclude();
  end
endmodule // test_dual_axis_accel_serial_port
